// ### pss_pkg.sv
// shared constants and types of the position sensor serial link
package pss_pkg;
    localparam int CLK_MHZ          = 200;
    localparam int NS_PER_US        = 1000;
    // minimum link times and the maximum release time, figures as specified
    localparam int T_BIT_FAST_NS    = 2300;
    localparam int T_BIT_SLOW_NS    = 6900;
    localparam int T_START_FAST_NS  = 15000;
    localparam int T_START_SLOW_NS  = 45000;
    localparam int T_BYTE_FAST_NS   = 12500;
    localparam int T_BYTE_SLOW_NS   = 37500;
    localparam int T_RESYNC_FAST_US = 300;
    localparam int T_RESYNC_SLOW_US = 1500;
    localparam int T_STARTUP_US     = 16000;
    localparam int T_SOFT_RESET_US  = 1000000;
    localparam int T_RELEASE_MAX_NS = 1000;

    function automatic int pss_ns_cyc(input int ns);
        return (ns * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    endfunction : pss_ns_cyc

    localparam int BIT_FAST_CYC     = pss_ns_cyc(T_BIT_FAST_NS);
    localparam int BIT_SLOW_CYC     = pss_ns_cyc(T_BIT_SLOW_NS);
    localparam int HALF_FAST_CYC    = (BIT_FAST_CYC + 1) / 2;
    localparam int HALF_SLOW_CYC    = (BIT_SLOW_CYC + 1) / 2;
    localparam int START_FAST_CYC   = pss_ns_cyc(T_START_FAST_NS);
    localparam int START_SLOW_CYC   = pss_ns_cyc(T_START_SLOW_NS);
    localparam int BYTE_FAST_CYC    = pss_ns_cyc(T_BYTE_FAST_NS);
    localparam int BYTE_SLOW_CYC    = pss_ns_cyc(T_BYTE_SLOW_NS);
    localparam int RESYNC_FAST_CYC  = T_RESYNC_FAST_US * CLK_MHZ;
    localparam int RESYNC_SLOW_CYC  = T_RESYNC_SLOW_US * CLK_MHZ;
    localparam int STARTUP_CYC      = T_STARTUP_US * CLK_MHZ;
    localparam int SOFT_RESET_CYC   = T_SOFT_RESET_US * CLK_MHZ;

    // frame layout, positions count sclk rising edges from 1
    localparam logic [7:0] START_BYTE     = 8'hFF;
    localparam logic [6:0] SYNC_POS       = 7'h03;
    localparam logic [6:0] LATCH_POS      = 7'h08;
    localparam logic [6:0] FIRST_DATA_POS = 7'h09;
    localparam logic [6:0] FRAME_BITS     = 7'h40;
    localparam logic [2:0] FLUSH_PULSES   = 3'h4;

    // error word bit positions
    localparam int ERR_ADC_MON   = 2;
    localparam int ERR_ADC_SAT   = 3;
    localparam int ERR_GAIN_LOW  = 4;
    localparam int ERR_GAIN_HIGH = 5;
    localparam int ERR_NORM_LOW  = 6;
    localparam int ERR_FIELD_LOW = 7;
    localparam int ERR_FIELD_HI  = 8;
    localparam int ERR_RO_CLIP   = 9;
    localparam int ERR_DZ_FIRST  = 11;
    localparam int ERR_DZ_SECOND = 15;

    typedef enum logic [1:0] {
        ST_START,
        ST_WAIT,
        ST_LINK,
        ST_DEAD
    } pss_dev_state_t;

    typedef enum logic [3:0] {
        H_FLUSH_HI,
        H_FLUSH_LO,
        H_SYNC,
        H_IDLE,
        H_LEAD,
        H_HI,
        H_LO,
        H_GAP,
        H_TAIL
    } pss_host_state_t;
endpackage : pss_pkg

// ### pss_if.sv
// three-wire link between the sensor slave and its master
`timescale 1ns/1ps
interface pss_if;
    logic sel_n;
    logic sclk;
    logic host_o;
    logic host_oe;
    logic dev_o;
    logic dev_oe;
    logic dio;

    // open-drain wire with external pull-up
    assign dio = !((host_oe && !host_o) || (dev_oe && !dev_o));

    modport dev (
        input  sel_n,
        input  sclk,
        input  dio,
        output dev_o,
        output dev_oe
    );

    modport host (
        output sel_n,
        output sclk,
        output host_o,
        output host_oe,
        input  dio
    );
endinterface : pss_if

// ### pss_dev.sv
// sensor slave end of the serial link
`timescale 1ns/1ps
module pss_dev #(
    parameter int STARTUP_CYC     = pss_pkg::STARTUP_CYC,
    parameter int RESYNC_FAST_CYC = pss_pkg::RESYNC_FAST_CYC,
    parameter int RESYNC_SLOW_CYC = pss_pkg::RESYNC_SLOW_CYC,
    parameter int SOFT_RESET_CYC  = pss_pkg::SOFT_RESET_CYC
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    pss_if.dev               link,
    input  wire logic        slow_mode,
    input  wire logic        frame_content_select,
    input  wire logic        meas_valid,
    input  wire logic [15:0] alpha,
    input  wire logic [15:0] beta,
    input  wire logic [15:0] field_x,
    input  wire logic [15:0] field_y,
    input  wire logic [15:0] field_z,
    input  wire logic        adc_monitor_fault,
    input  wire logic        adc_saturation_fault,
    input  wire logic        gain_below_min_flag,
    input  wire logic        gain_above_max_flag,
    input  wire logic        fast_norm_low_flag,
    input  wire logic        field_norm_low_flag,
    input  wire logic        field_norm_high_flag,
    input  wire logic        rough_offset_clip_flag,
    input  wire logic        first_angle_deadzone_flag,
    input  wire logic        second_angle_deadzone_flag,
    input  wire logic        soft_fault,
    input  wire logic        hard_fault,
    output logic             link_up,
    output logic             starting
);
    typedef struct packed {
        pss_pkg::pss_dev_state_t state;
        logic [31:0] cnt;
        logic [31:0] hi_cnt;
        logic [31:0] soft_cnt;
        logic        sel_s1;
        logic        sel_s2;
        logic        gen;
        logic        req_s1;
        logic        req_s2;
        logic        req_seen;
        logic        done_s1;
        logic        done_s2;
        logic        done_seen;
        logic        soft_pend;
        logic        drive_en;
        logic [15:0] alpha;
        logic [15:0] beta;
        logic [15:0] fx;
        logic [15:0] fy;
        logic [15:0] fz;
        logic [55:0] payload;
    } pss_dev_clk_t;

    typedef struct packed {
        logic       hold_s1;
        logic       hold_s2;
        logic       gen_s1;
        logic       gen_s2;
        logic       gen_seen;
        logic [6:0] pos;
        logic       drive;
        logic       req_tgl;
        logic       done_tgl;
    } pss_dev_lnk_t;

    pss_dev_clk_t r_reg;
    pss_dev_clk_t r_next;
    pss_dev_lnk_t l_reg;
    pss_dev_lnk_t l_next;
    logic [31:0]  thr;
    logic         frame_done;

    // error word from live flags
    function automatic logic [15:0] pss_err_word();
        logic [15:0] e;
        e = 16'h0000;
        e[pss_pkg::ERR_ADC_MON]   = adc_monitor_fault;
        e[pss_pkg::ERR_ADC_SAT]   = adc_saturation_fault;
        e[pss_pkg::ERR_GAIN_LOW]  = gain_below_min_flag;
        e[pss_pkg::ERR_GAIN_HIGH] = gain_above_max_flag;
        e[pss_pkg::ERR_NORM_LOW]  = fast_norm_low_flag;
        e[pss_pkg::ERR_FIELD_LOW] = field_norm_low_flag;
        e[pss_pkg::ERR_FIELD_HI]  = field_norm_high_flag;
        e[pss_pkg::ERR_RO_CLIP]   = rough_offset_clip_flag;
        e[pss_pkg::ERR_DZ_FIRST]  = first_angle_deadzone_flag;
        e[pss_pkg::ERR_DZ_SECOND] = second_angle_deadzone_flag;
        return e;
    endfunction : pss_err_word

    // data bytes in send order, then checksum
    function automatic logic [55:0] pss_payload(
        input logic [15:0] w0,
        input logic [15:0] w1,
        input logic [15:0] w2
    );
        logic [7:0] sum;
        sum = pss_pkg::START_BYTE + w0[7:0] + w0[15:8] + w1[7:0]
            + w1[15:8] + w2[7:0] + w2[15:8];
        return {w0[7:0], w0[15:8], w1[7:0], w1[15:8],
                w2[7:0], w2[15:8], sum};
    endfunction : pss_payload

    // system clock side
    always_comb begin
        r_next         = r_reg;
        thr            = slow_mode ? 32'(RESYNC_SLOW_CYC)
                                   : 32'(RESYNC_FAST_CYC);
        r_next.sel_s1  = link.sel_n;
        r_next.sel_s2  = r_reg.sel_s1;
        r_next.req_s1  = l_reg.req_tgl;
        r_next.req_s2  = r_reg.req_s1;
        r_next.done_s1 = l_reg.done_tgl;
        r_next.done_s2 = r_reg.done_s1;
        frame_done     = r_reg.done_s2 != r_reg.done_seen;
        r_next.done_seen = r_reg.done_s2;
        if (meas_valid) begin
            r_next.alpha = alpha;
            r_next.beta  = beta;
            r_next.fx    = field_x;
            r_next.fy    = field_y;
            r_next.fz    = field_z;
        end
        if (r_reg.req_s2 != r_reg.req_seen) begin
            r_next.req_seen = r_reg.req_s2;
            if (frame_content_select) begin
                r_next.payload = pss_payload(r_reg.fx, r_reg.fy,
                                             r_reg.fz);
            end else begin
                r_next.payload = pss_payload(r_reg.alpha, r_reg.beta,
                                             pss_err_word());
            end
        end
        if (r_reg.sel_s2 && r_reg.state != pss_pkg::ST_START) begin
            r_next.hi_cnt = (r_reg.hi_cnt == thr) ? r_reg.hi_cnt
                                                  : r_reg.hi_cnt + 32'h1;
        end else begin
            r_next.hi_cnt = 32'h0;
        end
        r_next.soft_pend = r_reg.soft_pend | soft_fault;
        r_next.soft_cnt  = r_reg.soft_pend ? r_reg.soft_cnt + 32'h1
                                           : 32'h0;
        unique case (r_reg.state)
            pss_pkg::ST_START: begin
                r_next.cnt = r_reg.cnt + 32'h1;
                if (r_reg.cnt == 32'(STARTUP_CYC - 1)) begin
                    r_next.state = pss_pkg::ST_WAIT;
                    r_next.cnt   = 32'h0;
                end
            end
            pss_pkg::ST_WAIT, pss_pkg::ST_LINK: begin
                if (r_reg.sel_s2 && r_reg.hi_cnt == thr - 32'h1) begin
                    r_next.gen   = ~r_reg.gen;
                    r_next.state = pss_pkg::ST_LINK;
                end
            end
            pss_pkg::ST_DEAD: begin
                r_next.cnt = 32'h0;
            end
        endcase
        if (r_reg.state != pss_pkg::ST_DEAD && r_reg.soft_pend &&
            (r_reg.soft_cnt == 32'(SOFT_RESET_CYC - 1) || frame_done))
        begin
            r_next.state     = pss_pkg::ST_START;
            r_next.cnt       = 32'h0;
            r_next.soft_pend = soft_fault;
            r_next.soft_cnt  = 32'h0;
        end
        if (hard_fault) begin
            r_next.state = pss_pkg::ST_DEAD;
        end
        r_next.drive_en = r_next.state == pss_pkg::ST_LINK &&
                          !r_reg.sel_s2;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            r_reg       <= '0;
            r_reg.state <= pss_pkg::ST_START;
        end else begin
            r_reg <= r_next;
        end
    end

    // link clock side, one step per sclk rising edge
    always_comb begin
        l_next         = l_reg;
        l_next.hold_s1 = r_reg.state != pss_pkg::ST_LINK;
        l_next.hold_s2 = l_reg.hold_s1;
        l_next.gen_s1  = r_reg.gen;
        l_next.gen_s2  = l_reg.gen_s1;
        if (l_reg.hold_s2) begin
            // toggles follow the quiet clk side while held
            l_next.pos      = 7'h00;
            l_next.gen_seen = l_reg.gen_s2;
            l_next.req_tgl  = r_reg.req_seen;
            l_next.done_tgl = r_reg.done_seen;
        end else if (l_reg.gen_s2 != l_reg.gen_seen) begin
            l_next.gen_seen = l_reg.gen_s2;
            l_next.pos      = pss_pkg::SYNC_POS;
        end else if (l_reg.pos == pss_pkg::FRAME_BITS) begin
            // park so later clocks send recessive ones
            l_next.pos = 7'h00;
        end else if (l_reg.pos != 7'h00) begin
            l_next.pos = l_reg.pos + 7'h01;
        end
        if (l_next.pos == pss_pkg::LATCH_POS &&
            l_reg.pos != pss_pkg::LATCH_POS) begin
            l_next.req_tgl = ~l_reg.req_tgl;
        end
        if (l_next.pos == pss_pkg::FRAME_BITS &&
            l_reg.pos != pss_pkg::FRAME_BITS) begin
            l_next.done_tgl = ~l_reg.done_tgl;
        end
        // start byte is all ones, so only data and checksum bits pull low
        l_next.drive = l_next.pos >= pss_pkg::FIRST_DATA_POS &&
            !r_reg.payload[6'(pss_pkg::FRAME_BITS - l_next.pos)];
    end

    always_ff @(posedge link.sclk) begin
        l_reg <= l_next;
    end

    assign link.dev_o  = 1'b0;
    assign link.dev_oe = l_reg.drive & r_reg.drive_en;
    assign link_up     = r_reg.state == pss_pkg::ST_LINK;
    assign starting    = r_reg.state == pss_pkg::ST_START;
endmodule : pss_dev

// ### pss_host.sv
// master end of the sensor serial link
`timescale 1ns/1ps
module pss_host #(
    parameter int RESYNC_FAST_CYC = pss_pkg::RESYNC_FAST_CYC,
    parameter int RESYNC_SLOW_CYC = pss_pkg::RESYNC_SLOW_CYC,
    parameter int START_SLOW_CYC  = pss_pkg::START_SLOW_CYC,
    parameter int BYTE_SLOW_CYC   = pss_pkg::BYTE_SLOW_CYC
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    pss_if.host              link,
    input  wire logic        slow_mode,
    input  wire logic        start,
    output logic             busy,
    output logic             done,
    output logic [15:0]      word0,
    output logic [15:0]      word1,
    output logic [15:0]      word2,
    output logic             sum_ok
);
    typedef struct packed {
        pss_pkg::pss_host_state_t state;
        logic [31:0] cnt;
        logic [2:0]  bitn;
        logic [2:0]  byten;
        logic        sclk;
        logic        sel_n;
        logic        dio_s1;
        logic        dio_s2;
        logic [63:0] shift;
        logic        done;
        logic [15:0] w0;
        logic [15:0] w1;
        logic [15:0] w2;
        logic        sum_ok;
    } pss_host_t;

    pss_host_t   h_reg;
    pss_host_t   h_next;
    logic [31:0] half;
    logic [31:0] lead;
    logic [31:0] gap;
    logic [31:0] thr;
    logic        tick;
    logic [7:0]  sum;

    always_comb begin
        h_next        = h_reg;
        half = slow_mode ? 32'(pss_pkg::HALF_SLOW_CYC)
                         : 32'(pss_pkg::HALF_FAST_CYC);
        lead = slow_mode ? 32'(pss_pkg::BIT_SLOW_CYC)
                         : 32'(pss_pkg::BIT_FAST_CYC);
        thr  = slow_mode ? 32'(RESYNC_SLOW_CYC)
                         : 32'(RESYNC_FAST_CYC);
        if (h_reg.byten == 3'h0) begin
            gap = slow_mode ? 32'(START_SLOW_CYC)
                            : 32'(pss_pkg::START_FAST_CYC);
        end else begin
            gap = slow_mode ? 32'(BYTE_SLOW_CYC)
                            : 32'(pss_pkg::BYTE_FAST_CYC);
        end
        sum = h_reg.shift[63:56] + h_reg.shift[55:48] + h_reg.shift[47:40]
            + h_reg.shift[39:32] + h_reg.shift[31:24] + h_reg.shift[23:16]
            + h_reg.shift[15:8];
        h_next.dio_s1 = link.dio;
        h_next.dio_s2 = h_reg.dio_s1;
        h_next.done   = 1'b0;
        h_next.cnt    = h_reg.cnt + 32'h1;
        tick          = 1'b0;
        unique case (h_reg.state)
            pss_pkg::H_FLUSH_HI, pss_pkg::H_HI:
                tick = h_reg.cnt == half - 32'h1;
            pss_pkg::H_FLUSH_LO, pss_pkg::H_LO:
                tick = h_reg.cnt == half - 32'h1;
            pss_pkg::H_SYNC:
                tick = h_reg.cnt == thr - 32'h1;
            pss_pkg::H_IDLE:
                tick = start;
            pss_pkg::H_LEAD, pss_pkg::H_TAIL:
                tick = h_reg.cnt == lead - 32'h1;
            pss_pkg::H_GAP:
                tick = h_reg.cnt == gap - 32'h1;
        endcase
        if (tick) begin
            h_next.cnt = 32'h0;
            unique case (h_reg.state)
                pss_pkg::H_FLUSH_HI: begin
                    h_next.sclk  = 1'b0;
                    h_next.state = pss_pkg::H_FLUSH_LO;
                end
                pss_pkg::H_FLUSH_LO: begin
                    h_next.bitn = h_reg.bitn + 3'h1;
                    if (h_reg.bitn == pss_pkg::FLUSH_PULSES - 3'h1) begin
                        h_next.state = pss_pkg::H_SYNC;
                    end else begin
                        h_next.sclk  = 1'b1;
                        h_next.state = pss_pkg::H_FLUSH_HI;
                    end
                end
                pss_pkg::H_SYNC: begin
                    h_next.state = pss_pkg::H_IDLE;
                end
                pss_pkg::H_IDLE: begin
                    h_next.sel_n = 1'b0;
                    h_next.bitn  = 3'h0;
                    h_next.byten = 3'h0;
                    h_next.state = pss_pkg::H_LEAD;
                end
                pss_pkg::H_LEAD, pss_pkg::H_GAP: begin
                    if (h_reg.state == pss_pkg::H_GAP) begin
                        h_next.byten = h_reg.byten + 3'h1;
                    end
                    h_next.sclk  = 1'b1;
                    h_next.state = pss_pkg::H_HI;
                end
                pss_pkg::H_HI: begin
                    h_next.sclk  = 1'b0;
                    h_next.shift = {h_reg.shift[62:0], h_reg.dio_s2};
                    h_next.state = pss_pkg::H_LO;
                end
                pss_pkg::H_LO: begin
                    h_next.bitn = h_reg.bitn + 3'h1;
                    if (h_reg.bitn != 3'h7) begin
                        h_next.sclk  = 1'b1;
                        h_next.state = pss_pkg::H_HI;
                    end else if (h_reg.byten == 3'h7) begin
                        h_next.state = pss_pkg::H_TAIL;
                    end else begin
                        h_next.state = pss_pkg::H_GAP;
                    end
                end
                pss_pkg::H_TAIL: begin
                    h_next.sel_n  = 1'b1;
                    h_next.done   = 1'b1;
                    h_next.w0     = {h_reg.shift[47:40], h_reg.shift[55:48]};
                    h_next.w1     = {h_reg.shift[31:24], h_reg.shift[39:32]};
                    h_next.w2     = {h_reg.shift[15:8], h_reg.shift[23:16]};
                    h_next.sum_ok = sum == h_reg.shift[7:0];
                    h_next.bitn   = 3'h0;
                    h_next.sclk   = 1'b1;
                    h_next.state  = pss_pkg::H_FLUSH_HI;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            h_reg       <= '0;
            h_reg.sel_n <= 1'b1;
            h_reg.state <= pss_pkg::H_FLUSH_LO;
        end else begin
            h_reg <= h_next;
        end
    end

    assign link.sel_n   = h_reg.sel_n;
    assign link.sclk    = h_reg.sclk;
    assign link.host_o  = 1'b0;
    assign link.host_oe = 1'b0;
    assign busy         = h_reg.state != pss_pkg::H_IDLE;
    assign done         = h_reg.done;
    assign word0        = h_reg.w0;
    assign word1        = h_reg.w1;
    assign word2        = h_reg.w2;
    assign sum_ok       = h_reg.sum_ok;
endmodule : pss_host

// ### pss_checker.sv
// wire-level assertions for the sensor serial link
`timescale 1ns/1ps
module pss_checker #(
    parameter int RESYNC_CYC = 300
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic dev_oe,
    input wire logic dio
);
    localparam int BIT_MIN   = pss_pkg::BIT_FAST_CYC - 2;
    localparam int START_MIN = pss_pkg::START_FAST_CYC - 2;
    localparam int BYTE_MIN  = pss_pkg::BYTE_FAST_CYC - 2;

    typedef struct packed {
        logic        sclk_d;
        logic        sel_d;
        logic [6:0]  edges;
        logic [19:0] per;
        logic [19:0] quiet;
        logic [19:0] hi;
    } pss_chk_t;

    pss_chk_t st_reg;
    pss_chk_t st_next;

    // rise count in frame, rise-to-rise and since-last-change cycles
    always_comb begin
        st_next        = st_reg;
        st_next.sclk_d = sclk;
        st_next.sel_d  = sel_n;
        st_next.per    = st_reg.per + 20'h1;
        st_next.quiet  = st_reg.quiet + 20'h1;
        st_next.hi     = sel_n ? st_reg.hi + 20'h1 : 20'h0;
        if (sclk != st_reg.sclk_d || sel_n != st_reg.sel_d) begin
            st_next.quiet = 20'h0;
        end
        if (sclk && !st_reg.sclk_d) begin
            st_next.per   = 20'h0;
            st_next.edges = st_reg.edges + 7'h1;
        end
        if (sel_n) begin
            st_next.edges = 7'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence sel_hold;
        sel_n [*4];
    endsequence
    sequence sclk_up;
        $rose(sclk) && !sel_n;
    endsequence
    sequence deselect;
        $rose(sel_n) && st_reg.edges != 7'h0;
    endsequence

    pin_release_a: assert property (sel_hold |-> !dev_oe && dio)
        else $error("pin still driven after deselect");
    shift_on_rise_a: assert property (
        $fell(sclk) && !sel_n |-> $stable(dev_oe))
        else $error("pin changed at sampling edge");
    start_ones_a: assert property (
        !sel_n && st_reg.edges <= 7'h8 && !(sclk && !st_reg.sclk_d)
        |-> !dev_oe)
        else $error("start byte not all ones");
    lead_time_a: assert property (
        sclk_up ##0 st_reg.edges == 7'h0 |-> st_reg.quiet >= BIT_MIN)
        else $error("first clock too soon after select");
    bit_period_a: assert property (
        sclk_up ##0 st_reg.edges[2:0] != 3'h0 |-> st_reg.per >= BIT_MIN)
        else $error("bit period too short");
    start_gap_a: assert property (
        sclk_up ##0 st_reg.edges == 7'h8 |-> st_reg.per >= START_MIN)
        else $error("start byte gap too short");
    byte_gap_a: assert property (
        sclk_up ##0 st_reg.edges[2:0] == 3'h0 && st_reg.edges > 7'h8
        |-> st_reg.per >= BYTE_MIN)
        else $error("byte gap too short");
    tail_time_a: assert property (deselect |-> st_reg.quiet >= BIT_MIN)
        else $error("deselect too soon after clock");
    frame_len_a: assert property (deselect |-> st_reg.edges == 7'h40)
        else $error("frame not 64 clocks");
    resync_gap_a: assert property (
        $fell(sel_n) |-> st_reg.hi >= RESYNC_CYC - 1)
        else $error("select high too short before frame");
endmodule : pss_checker

// ### tb_position_sensor_serial_slave.sv
// self-checking bench joining both ends of the sensor link
`timescale 1ns/1ps
module tb_position_sensor_serial_slave;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        host_nrst = 1'b0;
    logic        slow_mode = 1'b0;
    logic        content = 1'b0;
    logic        meas_valid = 1'b0;
    logic        soft_fault = 1'b0;
    logic        hard_fault = 1'b0;
    logic        start = 1'b0;
    logic [15:0] alpha = 16'h0, beta = 16'h0;
    logic [15:0] fx = 16'h0, fy = 16'h0, fz = 16'h0;
    logic [9:0]  flags = 10'h0;
    logic        link_up, starting, busy, done, sum_ok;
    logic [15:0] word0, word1, word2;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cyc = 0;

    always #2.5 clk = ~clk;

    pss_if pss_if_i ();
    pss_dev #(.STARTUP_CYC(200), .RESYNC_FAST_CYC(2000),
        .RESYNC_SLOW_CYC(2000), .SOFT_RESET_CYC(500)) pss_dev_i (
        .clk(clk), .nrst(nrst), .link(pss_if_i), .slow_mode(slow_mode),
        .frame_content_select(content), .meas_valid(meas_valid),
        .alpha(alpha), .beta(beta), .field_x(fx), .field_y(fy),
        .field_z(fz), .adc_monitor_fault(flags[0]),
        .adc_saturation_fault(flags[1]), .gain_below_min_flag(flags[2]),
        .gain_above_max_flag(flags[3]), .fast_norm_low_flag(flags[4]),
        .field_norm_low_flag(flags[5]), .field_norm_high_flag(flags[6]),
        .rough_offset_clip_flag(flags[7]),
        .first_angle_deadzone_flag(flags[8]),
        .second_angle_deadzone_flag(flags[9]), .soft_fault(soft_fault),
        .hard_fault(hard_fault), .link_up(link_up), .starting(starting));
    pss_host #(.RESYNC_FAST_CYC(2000), .RESYNC_SLOW_CYC(2000)) pss_host_i (
        .clk(clk), .nrst(host_nrst), .link(pss_if_i),
        .slow_mode(slow_mode), .start(start), .busy(busy), .done(done),
        .word0(word0), .word1(word1), .word2(word2), .sum_ok(sum_ok));
    pss_checker #(.RESYNC_CYC(2000)) pss_checker_i (
        .clk(clk), .nrst(host_nrst), .sel_n(pss_if_i.sel_n),
        .sclk(pss_if_i.sclk), .dev_oe(pss_if_i.dev_oe), .dio(pss_if_i.dio));

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wait_until(ref logic sig, input logic val, input int lim);
        for (int n = 0; n < lim && sig !== val; n++) begin
            @(negedge clk);
        end
        if (sig !== val) begin
            bad_count++;
            $display("unexpected wait: expected %b, seen %b", val, sig);
        end
    endtask : wait_until

    task automatic run_frame();
        wait_until(busy, 1'b0, 20000);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        wait_until(done, 1'b1, 60000);
    endtask : run_frame

    task automatic measure(input logic [15:0] a, b, x, y, z);
        {alpha, beta, fx, fy, fz} = {a, b, x, y, z};
        meas_valid = 1'b1;
        @(negedge clk);
        meas_valid = 1'b0;
    endtask : measure

    task automatic test_startup();
        chk("starting", 16'h1, {15'h0, starting});
        chk("link_up", 16'h0, {15'h0, link_up});
        wait_until(starting, 1'b0, 1000);
        host_nrst = 1'b1;
        wait_until(busy, 1'b0, 5000);
        chk("link_up", 16'h1, {15'h0, link_up});
        $display("test startup done");
    endtask : test_startup

    task automatic test_angles();
        content = 1'b0;
        flags = 10'h155;
        measure(16'h12A5, 16'hC03E, 16'h0, 16'h0, 16'h0);
        run_frame();
        chk("alpha", 16'h12A5, word0);
        chk("beta", 16'hC03E, word1);
        chk("error word", 16'h0954, word2);
        chk("sum", 16'h1, {15'h0, sum_ok});
        $display("test angles done");
    endtask : test_angles

    task automatic test_flags();
        content = 1'b0;
        flags = 10'h2AA;
        measure(16'h5A0F, 16'h0FF0, 16'h0, 16'h0, 16'h0);
        run_frame();
        chk("alpha", 16'h5A0F, word0);
        chk("beta", 16'h0FF0, word1);
        chk("error word", 16'h82A8, word2);
        chk("sum", 16'h1, {15'h0, sum_ok});
        $display("test flags done");
    endtask : test_flags

    task automatic test_latch();
        content = 1'b1;
        measure(16'h0, 16'h0, 16'h8001, 16'h7F10, 16'hA55A);
        fork
            run_frame();
            begin
                repeat (12000) @(negedge clk);
                measure(16'h1, 16'h2, 16'h3, 16'h4, 16'h5);
            end
        join
        chk("field x", 16'h8001, word0);
        chk("field y", 16'h7F10, word1);
        chk("field z", 16'hA55A, word2);
        chk("sum", 16'h1, {15'h0, sum_ok});
        $display("test latch done");
    endtask : test_latch

    task automatic test_dead();
        soft_fault = 1'b1;
        @(negedge clk);
        soft_fault = 1'b0;
        repeat (510) @(negedge clk);
        chk("starting", 16'h1, {15'h0, starting});
        hard_fault = 1'b1;
        repeat (4) @(negedge clk);
        hard_fault = 1'b0;
        repeat (4) @(negedge clk);
        chk("link_up", 16'h0, {15'h0, link_up});
        nrst = 1'b0;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        chk("starting", 16'h1, {15'h0, starting});
        $display("test dead done");
    endtask : test_dead

    task automatic end_sim();
        $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    always @(posedge clk) begin
        cyc++;
        if (cyc == 190000) begin
            bad_count++;
            end_sim();
        end
    end

    initial begin
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        test_startup();
        test_angles();
        test_flags();
        test_latch();
        test_dead();
        end_sim();
    end
endmodule : tb_position_sensor_serial_slave
